// ---- hdl/aps_sequencer.sv ----
// Conversion pacing, channel list scanning and triggered scan sequencing.
`timescale 1ns/100ps
`include "aps_map.svh"

// Functional notes
// - Internal pacing comes from a 24-bit down-counter on a 20 MHz time base.
// - Internal pacing starts a conversion on the active-low pacer pulse falling edge.
// - External pacing starts a conversion on each falling edge of the sample clock that finds no conversion busy.
// - With external pacing the conversion rate follows the input clock while each conversion ends within one clock period.
// - Each tick acquires one list entry; channel 32 samples all 16 digital lines.
// - A single read converts one channel at once, unpaced, and cannot be aborted.
// - Orderly stop finishes the sample count, delivers data, ignores later triggers.
// - Abrupt stop halts at once, discards pending data, ignores later triggers.
// - Continuous scan walks the list per tick, wraps, until full or stopped.
// - Per-entry rate is pacer rate divided by the list length.
// - Trigger-out is high while waiting for a trigger, low once triggered.
// - In continuous scan trigger-out falls on the trigger and stays low until stop or buffer full.
// - Software-retriggered scan does multiscan-count list passes per retrigger.
// - The list holds 1024 entries, giving at most 262,144 samples per trigger.
// - Burst interval in software-retriggered mode uses a 24-bit 20 MHz counter.
// - Software-retriggered trigger-out goes high after the burst until the retrigger.
// - Externally-retriggered scan does multiscan passes then waits for a retrigger edge.
// - Retrigger edges during a burst are ignored; only waiting edges count.
// - Externally-retriggered trigger-out is low during a burst, high while waiting.
// - An entry with its inhibit flag set has its converted value dropped.
module aps_sequencer
   import aps_pkg::*;
#(
   parameter int LIST_DEPTH = `APS_LIST_DEPTH
) (
   // Clock and reset.
   input wire logic clock,
   input wire logic reset,
   // Configuration.
   input wire logic pacerExternal,
   input wire logic [`APS_COUNTER_WIDTH-1:0] pacerDivisor,
   input wire logic [`APS_COUNTER_WIDTH-1:0] scanTimerDivisor,
   input wire logic [1:0] scanMode,
   input wire logic [`APS_MULTISCAN_WIDTH-1:0] multiscanLast,
   input wire logic [`APS_LIST_ADDR_WIDTH-1:0] listLast,
   input wire logic [`APS_SAMPLE_COUNT_WIDTH-1:0] sampleTarget,
   input wire logic retrigRising,
   // Channel list write port.
   input wire logic listWrite,
   input wire logic [`APS_LIST_ADDR_WIDTH-1:0] listWrAddr,
   input wire logic [`APS_CHANNEL_WIDTH-1:0] listWrChannel,
   input wire logic [`APS_GAIN_WIDTH-1:0] listWrGain,
   input wire logic listWrInhibit,
   // Commands and same-clock events.
   input wire logic startCmd,
   input wire logic trigEvent,
   input wire logic orderlyStop,
   input wire logic abruptStop,
   input wire logic bufferFull,
   input wire logic singleRead,
   input wire logic [`APS_CHANNEL_WIDTH-1:0] singleChannel,
   input wire logic [`APS_GAIN_WIDTH-1:0] singleGain,
   // Pins from outside.
   input wire logic extSampleClock,
   input wire logic extRetrigger,
   input wire logic [`APS_DATA_WIDTH-1:0] digitalLines,
   // Converter.
   output logic convStart,
   output logic [`APS_CHANNEL_WIDTH-1:0] convChannel,
   output logic [`APS_GAIN_WIDTH-1:0] convGain,
   input wire logic convDone,
   input wire logic [`APS_DATA_WIDTH-1:0] convData,
   // Results and status.
   output logic sampleValid,
   output logic [`APS_DATA_WIDTH-1:0] sampleData,
   output logic [`APS_LIST_ADDR_WIDTH-1:0] sampleEntry,
   output logic singleValid,
   output logic [`APS_DATA_WIDTH-1:0] singleData,
   output logic deliverPulse,
   output logic discardPulse,
   output logic pacerOutN,
   output logic trigOut,
   output logic busy
);

   aps_entry_t channelList [LIST_DEPTH];
   aps_regs_t q;
   aps_regs_t d;
   aps_entry_t cur;
   logic baseTick;
   logic pacerRun;
   logic timerRun;
   logic timerTerminal;
   logic tick;
   logic extFall;
   logic retrigEdge;
   logic digitalHit;
   logic acqDone;
   logic acqKeep;
   logic [`APS_DATA_WIDTH-1:0] acqData;
   logic lastSample;
   logic anyStop;

   function automatic logic [`APS_COUNTER_WIDTH-1:0] reloadValue(
      input logic [`APS_COUNTER_WIDTH-1:0] divisor);
      reloadValue = (divisor == `APS_RESET_COUNT) ? `APS_RESET_COUNT : divisor - 1'b1;
   endfunction : reloadValue

   // A level counts once the second and third stages agree.
   function automatic logic settled(input logic [2:0] sync, input logic lvl);
      settled = (sync[1] == sync[2]) ? sync[2] : lvl;
   endfunction : settled

   // The list is memory, written only by the host port.
   always_ff @(posedge clock) begin
      if (listWrite) begin
         channelList[listWrAddr] <= '{listWrInhibit, listWrGain, listWrChannel};
      end
   end

   assign cur = channelList[q.entry];

   always_comb begin
      d = q;
      d.convStart = 1'b0;
      d.sampleValid = 1'b0;
      d.singleValid = 1'b0;
      d.deliverPulse = 1'b0;
      d.discardPulse = 1'b0;
      d.pacerOutN = 1'b1;
      d.extClkSync = {q.extClkSync[1:0], extSampleClock};
      d.retrigSync = {q.retrigSync[1:0], extRetrigger};
      d.extClkLvl = settled(q.extClkSync, q.extClkLvl);
      d.retrigLvl = settled(q.retrigSync, q.retrigLvl);
      extFall = q.extClkLvl & ~d.extClkLvl;
      // The host picks the retrigger polarity; both polarities pass the same filter.
      retrigEdge = retrigRising ? (~q.retrigLvl & d.retrigLvl) : (q.retrigLvl & ~d.retrigLvl);

      // Time base of 20 MHz from the system clock.
      baseTick = (q.baseDiv == 3'h0);
      d.baseDiv = baseTick ? 3'(`APS_TIMEBASE_DIV - 1) : q.baseDiv - 3'h1;

      pacerRun = (q.state == APS_SCAN) && !pacerExternal;
      if (!pacerRun) begin
         d.pacerCnt = reloadValue(pacerDivisor);
      end else if (baseTick) begin
         if (q.pacerCnt == `APS_RESET_COUNT) begin
            d.pacerCnt = reloadValue(pacerDivisor);
            d.pacerOutN = 1'b0;
         end else begin
            d.pacerCnt = q.pacerCnt - 1'b1;
         end
      end

      // The burst timer runs from the initial trigger until the operation ends.
      timerRun = (scanMode == `APS_MODE_SW_RETRIG) &&
         ((q.state == APS_SCAN) || (q.state == APS_WAIT_RETRIG));
      timerTerminal = timerRun && baseTick && (q.scanTimerCnt == `APS_RESET_COUNT);
      if (!timerRun || timerTerminal) begin
         d.scanTimerCnt = reloadValue(scanTimerDivisor);
      end else if (baseTick) begin
         d.scanTimerCnt = q.scanTimerCnt - 1'b1;
      end

      // The falling edge of the pacer pulse starts a conversion; a tick that
      // lands while a conversion is still busy is dropped, one entry per tick.
      tick = (pacerExternal ? extFall : (q.pacerOutN && !d.pacerOutN)) &&
         (q.state == APS_SCAN) && !q.convBusy;
      d.pacerOutN = pacerRun ? d.pacerOutN : 1'b1;

      digitalHit = tick && (cur.channel == `APS_DIGITAL_CHANNEL);
      acqDone = digitalHit || (q.convBusy && convDone && (q.state == APS_SCAN));
      acqKeep = digitalHit ? !cur.inhibit : !q.convInhibit;
      acqData = digitalHit ? digitalLines : convData;
      anyStop = abruptStop && (q.state != APS_SINGLE) && (q.state != APS_IDLE);
      lastSample = (q.sampleCnt + 1'b1 >= sampleTarget);

      if (orderlyStop && ((q.state == APS_ARMED) || (q.state == APS_SCAN) ||
            (q.state == APS_WAIT_RETRIG))) begin
         d.orderlyPending = 1'b1;
      end

      unique case (q.state)
         APS_IDLE: begin
            d.orderlyPending = 1'b0;
            if (singleRead) begin
               // Channel 32 reads the digital lines itself, so no conversion is started.
               d.convStart = (singleChannel != `APS_DIGITAL_CHANNEL);
               d.convChannel = singleChannel;
               d.convGain = singleGain;
               d.state = APS_SINGLE;
            end else if (startCmd) begin
               d.state = APS_ARMED;
            end
         end
         APS_SINGLE: begin
            // Stops are not looked at here: a single read always runs out.
            if (q.convChannel == `APS_DIGITAL_CHANNEL) begin
               d.singleValid = 1'b1;
               d.singleData = digitalLines;
               d.state = APS_IDLE;
            end else if (convDone) begin
               d.singleValid = 1'b1;
               d.singleData = convData;
               d.state = APS_IDLE;
            end
         end
         APS_ARMED: begin
            if (trigEvent) begin
               d.state = APS_SCAN;
               d.entry = '0;
               d.scanCnt = '0;
               d.sampleCnt = '0;
            end
         end
         APS_SCAN: begin
            if (tick) begin
               d.convEntry = q.entry;
               d.convInhibit = cur.inhibit;
               d.convBurstEnd = (q.entry == listLast) && (q.scanCnt == multiscanLast);
               if (!digitalHit) begin
                  d.convStart = 1'b1;
                  d.convChannel = cur.channel;
                  d.convGain = cur.gain;
                  d.convBusy = 1'b1;
               end
               if (q.entry == listLast) begin
                  d.entry = '0;
                  d.scanCnt = q.scanCnt + 1'b1;
               end else begin
                  d.entry = q.entry + 1'b1;
               end
            end
            if (acqDone) begin
               d.convBusy = 1'b0;
               d.sampleCnt = q.sampleCnt + 1'b1;
               if (acqKeep) begin
                  d.sampleValid = 1'b1;
                  d.sampleData = acqData;
                  d.sampleEntry = digitalHit ? q.entry : q.convEntry;
               end
               if (bufferFull || (q.orderlyPending && lastSample)) begin
                  d.deliverPulse = 1'b1;
                  d.state = APS_IDLE;
               end else if ((scanMode != `APS_MODE_CONTINUOUS) &&
                     (digitalHit ? ((q.entry == listLast) && (q.scanCnt == multiscanLast))
                      : q.convBurstEnd)) begin
                  d.scanCnt = '0;
                  d.state = APS_WAIT_RETRIG;
               end
            end
         end
         APS_WAIT_RETRIG: begin
            if (q.orderlyPending && (q.sampleCnt >= sampleTarget)) begin
               d.deliverPulse = 1'b1;
               d.state = APS_IDLE;
            end else if (((scanMode == `APS_MODE_SW_RETRIG) && timerTerminal) ||
                  ((scanMode == `APS_MODE_EXT_RETRIG) && retrigEdge)) begin
               d.state = APS_SCAN;
            end
         end
      endcase

      if (anyStop) begin
         d.state = APS_IDLE;
         d.convBusy = 1'b0;
         d.convStart = 1'b0;
         d.sampleValid = 1'b0;
         d.deliverPulse = 1'b0;
         d.discardPulse = 1'b1;
         d.orderlyPending = 1'b0;
      end

      d.trigOut = (d.state != APS_SCAN);
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         q <= '{state: APS_IDLE, pacerOutN: 1'b1, trigOut: 1'b1,
            extClkLvl: 1'b1, retrigLvl: 1'b1, extClkSync: 3'h7, retrigSync: 3'h7,
            default: '0};
      end else begin
         q <= d;
      end
   end

   assign convStart = q.convStart;
   assign convChannel = q.convChannel;
   assign convGain = q.convGain;
   assign sampleValid = q.sampleValid;
   assign sampleData = q.sampleData;
   assign sampleEntry = q.sampleEntry;
   assign singleValid = q.singleValid;
   assign singleData = q.singleData;
   assign deliverPulse = q.deliverPulse;
   assign discardPulse = q.discardPulse;
   assign pacerOutN = q.pacerOutN;
   assign trigOut = q.trigOut;
   assign busy = (q.state != APS_IDLE);

endmodule : aps_sequencer

// ---- hdl/aps_map.svh ----
// Constants for the conversion pacing and scan sequencer.
`ifndef APS_MAP_SVH
`define APS_MAP_SVH

`define APS_CLOCK_MHZ 100
`define APS_TIMEBASE_MHZ 20
`define APS_TIMEBASE_DIV (`APS_CLOCK_MHZ / `APS_TIMEBASE_MHZ)
`define APS_COUNTER_WIDTH 24
`define APS_LIST_DEPTH 1024
`define APS_LIST_ADDR_WIDTH 10
`define APS_MULTISCAN_WIDTH 8
`define APS_CHANNEL_WIDTH 6
`define APS_GAIN_WIDTH 2
`define APS_DATA_WIDTH 16
`define APS_SAMPLE_COUNT_WIDTH 32
`define APS_DIGITAL_CHANNEL 6'h20
`define APS_MODE_CONTINUOUS 2'h0
`define APS_MODE_SW_RETRIG 2'h1
`define APS_MODE_EXT_RETRIG 2'h2
`define APS_RESET_COUNT 24'h00_0000
`define APS_RESET_DATA 16'h0000

`endif

// ---- hdl/aps_pkg.sv ----
// Types shared by the conversion pacing and scan sequencer.
`include "aps_map.svh"

package aps_pkg;

   typedef enum logic [5:0] {
      APS_IDLE = 6'b00_0001,
      APS_ARMED = 6'b00_0010,
      APS_SCAN = 6'b00_0100,
      APS_WAIT_RETRIG = 6'b00_1000,
      APS_SINGLE = 6'b01_0000
   } aps_state_t;

   typedef struct packed {
      logic inhibit;
      logic [`APS_GAIN_WIDTH-1:0] gain;
      logic [`APS_CHANNEL_WIDTH-1:0] channel;
   } aps_entry_t;

   typedef struct packed {
      aps_state_t state;
      logic [2:0] baseDiv;
      logic [`APS_COUNTER_WIDTH-1:0] pacerCnt;
      logic [`APS_COUNTER_WIDTH-1:0] scanTimerCnt;
      logic [`APS_LIST_ADDR_WIDTH-1:0] entry;
      logic [`APS_MULTISCAN_WIDTH-1:0] scanCnt;
      logic [`APS_SAMPLE_COUNT_WIDTH-1:0] sampleCnt;
      logic [2:0] extClkSync;
      logic [2:0] retrigSync;
      logic extClkLvl;
      logic retrigLvl;
      logic orderlyPending;
      logic convBusy;
      logic convInhibit;
      logic convBurstEnd;
      logic [`APS_LIST_ADDR_WIDTH-1:0] convEntry;
      logic pacerOutN;
      logic trigOut;
      logic convStart;
      logic [`APS_CHANNEL_WIDTH-1:0] convChannel;
      logic [`APS_GAIN_WIDTH-1:0] convGain;
      logic sampleValid;
      logic [`APS_DATA_WIDTH-1:0] sampleData;
      logic [`APS_LIST_ADDR_WIDTH-1:0] sampleEntry;
      logic singleValid;
      logic [`APS_DATA_WIDTH-1:0] singleData;
      logic deliverPulse;
      logic discardPulse;
   } aps_regs_t;

endpackage : aps_pkg

// ---- test/aps_conv_model.sv ----
// Behavioural converter that answers the sequencer's start pulses.
`timescale 1ns/100ps
`include "aps_map.svh"
module aps_conv_model (
   // Clock, reset and answer speed.
   input wire logic clock,
   input wire logic reset,
   input wire logic slow,
   // Converter interface.
   input wire logic convStart,
   input wire logic [`APS_CHANNEL_WIDTH-1:0] convChannel,
   input wire logic [`APS_GAIN_WIDTH-1:0] convGain,
   output logic convDone,
   output logic [`APS_DATA_WIDTH-1:0] convData
);
   logic [4:0] wait_q;
   logic [15:0] result_q;
   logic [15:0] noise_q;
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         wait_q <= 5'h00;
         result_q <= 16'h0000;
         noise_q <= 16'h0000;
         convDone <= 1'b0;
      end else begin
         noise_q <= noise_q + 16'h1357;
         convDone <= 1'b0;
         if (convStart) begin
            wait_q <= slow ? 5'h0C : 5'h01;
            result_q <= {8'hC0, convGain, convChannel};
         end else if (wait_q == 5'h01) begin
            wait_q <= 5'h00;
            convDone <= 1'b1;
         end else if (wait_q != 5'h00) begin
            wait_q <= wait_q - 5'h01;
         end
      end
   end
   // Data is only valid with the done pulse; otherwise it wanders so stale reads show.
   assign convData = convDone ? result_q : noise_q;
endmodule : aps_conv_model

// ---- test/aps_sequencer_chk.sv ----
// Port-level assertions for the conversion pacing and scan sequencer.
`timescale 1ns/100ps
`include "aps_map.svh"
module aps_sequencer_chk (
   // Clock and reset.
   input wire logic clock,
   input wire logic reset,
   // Inputs watched.
   input wire logic pacerExternal,
   input wire logic [`APS_COUNTER_WIDTH-1:0] pacerDivisor,
   input wire logic startCmd,
   input wire logic trigEvent,
   input wire logic abruptStop,
   input wire logic singleRead,
   input wire logic [`APS_CHANNEL_WIDTH-1:0] singleChannel,
   input wire logic [`APS_GAIN_WIDTH-1:0] singleGain,
   input wire logic convDone,
   input wire logic [`APS_DATA_WIDTH-1:0] convData,
   // Outputs watched.
   input wire logic convStart,
   input wire logic [`APS_CHANNEL_WIDTH-1:0] convChannel,
   input wire logic [`APS_GAIN_WIDTH-1:0] convGain,
   input wire logic sampleValid,
   input wire logic singleValid,
   input wire logic [`APS_DATA_WIDTH-1:0] singleData,
   input wire logic deliverPulse,
   input wire logic discardPulse,
   input wire logic pacerOutN,
   input wire logic trigOut,
   input wire logic busy
);
   logic [31:0] gap_q;
   logic seen_q;
   logic single_q;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (reset);
   // The first pulse after entering a scan follows the load, not a reload, so it is skipped.
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         gap_q <= 32'h0000_0000;
         seen_q <= 1'b0;
         single_q <= 1'b0;
      end else begin
         gap_q <= pacerOutN ? gap_q + 32'h0000_0001 : 32'h0000_0001;
         seen_q <= !trigOut && (seen_q || !pacerOutN);
         single_q <= (singleRead && !busy) || (single_q && !singleValid);
      end
   end
   a_pacer_period: assert property (!pacerOutN && seen_q && !pacerExternal |->
      gap_q == 32'(pacerDivisor) * 32'h0000_0005) else $error("pacer period wrong");
   a_pacer_pulse: assert property (!pacerOutN |=> pacerOutN)
      else $error("pacer pulse too long");
   a_pacer_conv: assert property (convStart && !trigOut && !pacerExternal |->
      !pacerOutN && $past(pacerOutN)) else $error("conversion not on pacer fall");
   a_trig_fall: assert property ((startCmd && !busy && !singleRead) ##1
      !abruptStop ##1 (trigEvent && !abruptStop) |=> !trigOut)
      else $error("trigger out did not fall");
   a_idle_trig: assert property (!busy |-> trigOut)
      else $error("trigger out low while idle");
   a_abrupt_halt: assert property (abruptStop && !trigOut |=>
      discardPulse && !busy && !sampleValid ##1 (!sampleValid) [*4])
      else $error("abrupt stop did not halt");
   a_idle_stays: assert property (!busy && !startCmd && !singleRead |=> !busy)
      else $error("left idle without command");
   a_deliver_idle: assert property (deliverPulse |-> ##[0:1] !busy)
      else $error("deliver without stop");
   a_single_go: assert property (singleRead && !busy && singleChannel != `APS_DIGITAL_CHANNEL
      |=> convStart && convChannel == $past(singleChannel) && convGain == $past(singleGain))
      else $error("single read start wrong");
   a_single_data: assert property (convDone && single_q |=>
      singleValid && singleData == $past(convData)) else $error("single result wrong");
endmodule : aps_sequencer_chk

bind aps_sequencer aps_sequencer_chk u_aps_sequencer_chk (.*);

// ---- test/aps_sequencer_tb.sv ----
// Self-checking bench for the conversion pacing and scan sequencer.
`timescale 1ns/100ps
`include "aps_map.svh"
module aps_sequencer_tb;
   logic clock, reset, pacerExternal, retrigRising, listWrite, listWrInhibit, startCmd, trigEvent;
   logic orderlyStop, abruptStop, bufferFull, singleRead, extSampleClock, extRetrigger, slow, extRun;
   logic convStart, convDone, sampleValid, singleValid, deliverPulse, discardPulse, pacerOutN;
   logic trigOut, busy;
   logic [23:0] pacerDivisor, scanTimerDivisor;
   logic [1:0] scanMode, listWrGain, singleGain, convGain;
   logic [7:0] multiscanLast;
   logic [9:0] listLast, listWrAddr, sampleEntry;
   logic [31:0] sampleTarget;
   logic [5:0] listWrChannel, singleChannel, convChannel;
   logic [15:0] digitalLines, convData, sampleData, singleData;
   int n_errors, checked, cyc, t0;
   aps_sequencer u_aps_sequencer (.*);
   aps_conv_model u_aps_conv_model (.*);
   always #5 clock = ~clock;
   always @(posedge clock) cyc <= cyc + 1;
   // External sample clock with a 30-cycle period, only while a scan uses it.
   always @(posedge clock) if (extRun && cyc % 15 == 0) extSampleClock <= ~extSampleClock;
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : final_report
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   function automatic logic pick(input int sel);
      case (sel)
         0: return sampleValid;
         1: return trigOut;
         2: return !trigOut;
         3: return singleValid;
         default: return deliverPulse;
      endcase
   endfunction : pick
   task automatic await(input int sel, input int lim);
      int i;
      i = 0;
      do begin
         @(posedge clock);
         #1;
         i++;
      end while (pick(sel) !== 1'b1 && i < lim);
      if (pick(sel) !== 1'b1) begin
         n_errors++;
         $display("MISMATCH wait %0d expected 1 seen 0", sel);
         final_report();
      end
   endtask : await
   task automatic sample(input logic [9:0] e, input logic [15:0] d, input int lim);
      await(0, lim);
      chk("sampleEntry", 32'(e), 32'(sampleEntry));
      chk("sampleData", 32'(d), 32'(sampleData));
   endtask : sample
   // Order: start, trigger, orderly stop, abrupt stop, single read.
   task automatic cmd(input logic [4:0] c);
      @(posedge clock);
      {startCmd, trigEvent, orderlyStop, abruptStop, singleRead} <= c;
      @(posedge clock);
      {startCmd, trigEvent, orderlyStop, abruptStop, singleRead} <= 5'h00;
      #1;
   endtask : cmd
   task automatic wr(input logic [9:0] a, input logic [5:0] ch, input logic [1:0] g, input logic h);
      @(posedge clock);
      {listWrite, listWrAddr, listWrChannel, listWrGain, listWrInhibit} <= {1'b1, a, ch, g, h};
      @(posedge clock);
      listWrite <= 1'b0;
   endtask : wr
   task automatic cfg(input logic [1:0] m, input logic [9:0] l, input logic [7:0] s, input logic x);
      @(posedge clock);
      {scanMode, listLast, multiscanLast, pacerExternal, extRun} <= {m, l, s, x, x};
   endtask : cfg
   function automatic logic [15:0] cv(input logic [1:0] g, input logic [5:0] ch);
      return {8'hC0, g, ch};
   endfunction : cv
   initial begin
      {clock, pacerExternal, listWrite, listWrInhibit, startCmd, trigEvent, orderlyStop} = 7'h00;
      {abruptStop, bufferFull, singleRead, extSampleClock, slow, extRun, extRetrigger} = 7'h00;
      {reset, retrigRising, cyc, n_errors, checked} = {2'h3, 96'h0};
      {scanMode, multiscanLast, listLast, listWrAddr, listWrChannel, listWrGain} = 38'h0;
      {singleChannel, singleGain, digitalLines, sampleTarget} = {8'h00, 16'hBEEF, 32'h0000_0006};
      {pacerDivisor, scanTimerDivisor} = {24'h00_0004, 24'h00_0050};
      repeat (4) @(posedge clock);
      reset <= 1'b0;
      wr(0, 3, 1, 0);
      wr(1, `APS_DIGITAL_CHANNEL, 0, 0);
      wr(2, 5, 0, 1);
      wr(3, 7, 2, 0);
      cfg(`APS_MODE_CONTINUOUS, 3, 0, 0);
      cmd(5'h10);
      chk("armedTrigOut", 1, 32'(trigOut));
      cmd(5'h08);
      chk("scanTrigOut", 0, 32'(trigOut));
      sample(0, cv(1, 3), 60);
      t0 = cyc;
      sample(1, 16'hBEEF, 30);
      sample(3, cv(2, 7), 50);
      sample(0, cv(1, 3), 30);
      chk("entryPeriod", 80, 32'(cyc - t0));
      chk("runTrigOut", 0, 32'(trigOut));
      cmd(5'h02);
      chk("discard", 2, 32'({discardPulse, busy}));
      cmd(5'h08);
      chk("ignoredTrig", 3'h4, 32'({trigOut, busy, sampleValid}));
      wr(0, 1, 0, 0);
      wr(1, 2, 3, 0);
      cfg(`APS_MODE_SW_RETRIG, 1, 1, 0);
      cmd(5'h10);
      cmd(5'h08);
      sample(0, cv(0, 1), 60);
      t0 = cyc;
      sample(1, cv(3, 2), 30);
      sample(0, cv(0, 1), 30);
      sample(1, cv(3, 2), 30);
      await(1, 30);
      sample(0, cv(0, 1), 400);
      chk("burstPeriod", 400, 32'(cyc - t0));
      chk("burstTrigOut", 0, 32'(trigOut));
      cmd(5'h04);
      sample(1, cv(3, 2), 30);
      chk("deliver", 1, 32'(deliverPulse));
      cmd(5'h08);
      repeat (60) @(posedge clock);
      chk("afterStop", 2, 32'({trigOut, busy}));
      cfg(`APS_MODE_EXT_RETRIG, 1, 0, 1);
      cmd(5'h10);
      cmd(5'h08);
      sample(0, cv(0, 1), 80);
      t0 = cyc;
      @(posedge clock);
      extRetrigger <= 1'b1;
      repeat (6) @(posedge clock);
      extRetrigger <= 1'b0;
      sample(1, cv(3, 2), 40);
      chk("extPeriod", 30, 32'(cyc - t0));
      await(1, 20);
      repeat (100) @(posedge clock);
      chk("heldWait", 1, 32'(trigOut));
      extRetrigger <= 1'b1;
      await(2, 12);
      sample(0, cv(0, 1), 60);
      @(posedge clock);
      retrigRising <= 1'b0;
      sample(1, cv(3, 2), 40);
      await(1, 20);
      @(posedge clock);
      extRetrigger <= 1'b0;
      await(2, 12);
      @(posedge clock);
      bufferFull <= 1'b1;
      sample(0, cv(0, 1), 60);
      chk("fullEnd", 2, 32'({deliverPulse, busy}));
      cmd(5'h02);
      @(posedge clock);
      {slow, extRun, bufferFull, singleChannel, singleGain} <= {3'h4, 6'h09, 2'h3};
      cmd(5'h01);
      cmd(5'h02);
      await(3, 30);
      chk("singleData", 32'(cv(3, 9)), 32'(singleData));
      @(posedge clock);
      {singleChannel, digitalLines} <= {`APS_DIGITAL_CHANNEL, 16'h5A3C};
      cmd(5'h01);
      await(3, 5);
      chk("singleDigital", 32'h0000_5A3C, 32'(singleData));
      repeat (4) @(posedge clock);
      chk("singleEnd", 0, 32'(busy));
      final_report();
   end
endmodule : aps_sequencer_tb
